// File: rtl/ttc_unit.sv
// Purpose: Three timer/counters with baud and clock-out functions
// Assumes: Pins asynchronous; CPU control bits synchronous to clk
// Notes: Software flag writes are pulse ports; set wins over clear
`timescale 1ns/1ps
`default_nettype none
module ttc_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic mode_12t,
  // Pins
  input wire logic ctr0_count_pin,
  input wire logic ctr1_count_pin,
  input wire logic ctr2_count_pin,
  input wire logic ext_int0_pin,
  input wire logic ext_int1_pin,
  input wire logic ctr2_trigger_pin,
  output logic clock_out_pin,
  output logic clock_out_oe_n,
  // Counter 0/1 control
  input wire logic [1:0] ctr0_mode,
  input wire logic ctr0_counter_select,
  input wire logic ctr0_gate,
  input wire logic ctr0_run,
  input wire logic [1:0] ctr1_mode,
  input wire logic ctr1_counter_select,
  input wire logic ctr1_gate,
  input wire logic ctr1_run,
  // Counter 2 control
  input wire logic ctr2_run,
  input wire logic ctr2_counter_select,
  input wire logic capture_not_reload,
  input wire logic ctr2_trigger_allow,
  input wire logic down_count_allow,
  input wire logic tx_baud_from_ctr2,
  input wire logic rx_baud_from_ctr2,
  input wire logic clock_out_enable,
  input wire logic [7:0] reload_capture_low_in,
  input wire logic [7:0] reload_capture_high_in,
  // Software writes, one-cycle pulses
  input wire logic [15:0] ctr0_wdata,
  input wire logic ctr0_wr,
  input wire logic [15:0] ctr1_wdata,
  input wire logic ctr1_wr,
  input wire logic [15:0] ctr2_wdata,
  input wire logic ctr2_wr,
  input wire logic rcap_wr,
  input wire logic [3:0] flag_sw_set,
  input wire logic [3:0] flag_sw_clr,
  // Interrupt vectoring, one-cycle pulses
  input wire logic ctr0_vector_ack,
  input wire logic ctr1_vector_ack,
  // Status
  output logic [15:0] ctr0_count,
  output logic [15:0] ctr1_count,
  output logic [15:0] ctr2_count,
  output logic [7:0] reload_capture_low,
  output logic [7:0] reload_capture_high,
  output logic ctr0_overflow_flag,
  output logic ctr1_overflow_flag,
  output logic ctr2_overflow_flag,
  output logic ctr2_external_flag,
  output logic ctr0_irq,
  output logic ctr1_irq,
  output logic ctr2_irq,
  output logic tx_baud_tick,
  output logic rx_baud_tick
);
  import ttc_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers and machine cycle
  // ----------------------------------------------------------------
  logic [5:0] pin_s;
  logic [2:0] cpin_prev_r;
  logic trig_prev_r;
  logic tick;
  logic t0pin, t1pin, t2pin, int0, int1, trig;

  ttc_sync #(.W(6)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({ctr2_trigger_pin, ext_int1_pin, ext_int0_pin, ctr2_count_pin,
        ctr1_count_pin, ctr0_count_pin}),
    .q(pin_s)
  );

  ttc_mcycle u_mc (
    .clk(clk),
    .reset(reset),
    .mode_12t(mode_12t),
    .tick(tick)
  );

  assign {trig, int1, int0, t2pin, t1pin, t0pin} = pin_s;

  // Pins sampled once per machine cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      cpin_prev_r <= 3'h0;
      trig_prev_r <= 1'b0;
    end else if (tick) begin
      cpin_prev_r <= {t2pin, t1pin, t0pin};
      trig_prev_r <= trig;
    end
  end

  logic [2:0] cfall;
  logic trig_fall;
  assign cfall = cpin_prev_r & ~{t2pin, t1pin, t0pin} & {3{tick}};
  assign trig_fall = tick & trig_prev_r & ~trig;

  function automatic logic enabled(input logic run, input logic gate,
                                   input logic pin);
    enabled = run & (~gate | pin);
  endfunction

  // ----------------------------------------------------------------
  // Counters 0 and 1
  // ----------------------------------------------------------------
  logic [15:0] c0_nxt, c1_nxt;
  logic c0_ovf, c1_ovf, th0_ovf;
  logic inc0, inc1, inc_th0;

  assign inc0 = enabled(ctr0_run, ctr0_gate, int0) & (ctr0_counter_select ? cfall[0] : tick);
  assign inc1 = enabled(ctr1_run, ctr1_gate, int1) & (ctr1_counter_select ? cfall[1] : tick);
  assign inc_th0 = ctr1_run & tick;

  function automatic logic [16:0] step01(input logic [1:0] m, input logic [15:0] c,
                                         input logic inc);
    logic [15:0] n;
    logic o;
    n = c;
    o = 1'b0;
    if (inc) begin
      unique case (m)
        TTC_M13: begin
          if (c[TTC_PRESCALE_MSB:0] == TTC_PRESCALE_MAX) begin
            n[TTC_PRESCALE_MSB:0] = 5'h00;
            n[15:8] = c[15:8] + 8'h01;
            o = (c[15:8] == 8'hff);
          end else begin
            n[TTC_PRESCALE_MSB:0] = c[TTC_PRESCALE_MSB:0] + 5'h01;
          end
        end
        TTC_M16: begin
          n = c + 16'h0001;
          o = (c == 16'hffff);
        end
        TTC_M8R, TTC_MSPLIT: begin
          o = (c[7:0] == 8'hff);
          n[7:0] = (o && m == TTC_M8R) ? c[15:8] : c[7:0] + 8'h01;
        end
      endcase
    end
    step01 = {o, n};
  endfunction

  always_comb begin
    {c0_ovf, c0_nxt} = step01(ctr0_mode, ctr0_count, inc0);
    th0_ovf = 1'b0;
    if (ctr0_mode == TTC_MSPLIT && inc_th0) begin
      c0_nxt[15:8] = ctr0_count[15:8] + 8'h01;
      th0_ovf = (ctr0_count[15:8] == 8'hff);
    end
    if (ctr1_mode == TTC_MSPLIT) begin
      {c1_ovf, c1_nxt} = {1'b0, ctr1_count};
    end else begin
      {c1_ovf, c1_nxt} = step01(ctr1_mode, ctr1_count, inc1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctr0_count <= TTC_RESET_COUNT;
      ctr1_count <= TTC_RESET_COUNT;
    end else begin
      ctr0_count <= ctr0_wr ? ctr0_wdata : c0_nxt;
      ctr1_count <= ctr1_wr ? ctr1_wdata : c1_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Counter 2
  // ----------------------------------------------------------------
  ttc_c2mode_t c2mode;
  logic baud_sel, inc2, up2, c2_ovf, c2_load_trig, c2_capture;
  logic [15:0] c2_nxt;

  always_comb begin
    baud_sel = tx_baud_from_ctr2 | rx_baud_from_ctr2;
    if (!ctr2_run) c2mode = TTC_C2_OFF;
    else if (baud_sel) c2mode = TTC_C2_BAUD;
    else if (capture_not_reload) c2mode = TTC_C2_CAPTURE;
    else if (!down_count_allow) c2mode = TTC_C2_UP_ONLY;
    else c2mode = TTC_C2_UP_DOWN;
  end

  assign inc2 = (c2mode != TTC_C2_OFF) & (ctr2_counter_select ? cfall[2] : tick);
  assign up2 = (c2mode != TTC_C2_UP_DOWN) | trig;
  assign c2_capture = (c2mode == TTC_C2_CAPTURE) & ctr2_trigger_allow & trig_fall;
  assign c2_load_trig = (c2mode == TTC_C2_UP_ONLY) & ctr2_trigger_allow & trig_fall;

  always_comb begin
    c2_ovf = 1'b0;
    c2_nxt = ctr2_count;
    if (inc2) begin
      if (up2) begin
        c2_ovf = (ctr2_count == 16'hffff);
        c2_nxt = ctr2_count + 16'h0001;
      end else begin
        c2_ovf = (ctr2_count == {reload_capture_high, reload_capture_low});
        c2_nxt = ctr2_count - 16'h0001;
      end
      if (c2_ovf && c2mode != TTC_C2_CAPTURE) begin
        c2_nxt = up2 ? {reload_capture_high, reload_capture_low} : TTC_DOWN_LOAD;
      end
    end
    if (c2_load_trig) c2_nxt = {reload_capture_high, reload_capture_low};
    if (ctr2_wr) c2_nxt = ctr2_wdata;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctr2_count <= TTC_RESET_COUNT;
      reload_capture_low <= 8'h00;
      reload_capture_high <= 8'h00;
    end else begin
      ctr2_count <= c2_nxt;
      if (c2_capture) begin
        {reload_capture_high, reload_capture_low} <= ctr2_count;
      end else if (rcap_wr) begin
        reload_capture_low <= reload_capture_low_in;
        reload_capture_high <= reload_capture_high_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags, interrupts, baud ticks, clock out
  // ----------------------------------------------------------------
  logic clkout_mode, tf2_set, ctr2_external_flag_set, ctr2_external_flag_tog;
  assign clkout_mode = clock_out_enable & ~ctr2_counter_select;
  assign tf2_set = c2_ovf & ~baud_sel & ~clkout_mode;
  assign ctr2_external_flag_set = ctr2_trigger_allow & trig_fall &
                    (c2mode == TTC_C2_CAPTURE || c2mode == TTC_C2_UP_ONLY ||
                     c2mode == TTC_C2_BAUD);
  assign ctr2_external_flag_tog = c2_ovf & (c2mode == TTC_C2_UP_DOWN);

  function automatic logic flag_nxt(input logic cur, input logic hw_set,
                                    input logic sw_set, input logic clr);
    flag_nxt = hw_set | sw_set | (cur & ~clr);
  endfunction

  always_ff @(posedge clk) begin
    if (reset) begin
      ctr0_overflow_flag <= 1'b0;
      ctr1_overflow_flag <= 1'b0;
      ctr2_overflow_flag <= 1'b0;
      ctr2_external_flag <= 1'b0;
    end else begin
      ctr0_overflow_flag <= flag_nxt(ctr0_overflow_flag, c0_ovf, flag_sw_set[0],
                                     flag_sw_clr[0] | ctr0_vector_ack);
      ctr1_overflow_flag <= flag_nxt(ctr1_overflow_flag,
                                     (ctr0_mode == TTC_MSPLIT) ? th0_ovf : c1_ovf,
                                     flag_sw_set[1], flag_sw_clr[1] | ctr1_vector_ack);
      ctr2_overflow_flag <= flag_nxt(ctr2_overflow_flag, tf2_set, flag_sw_set[2],
                                     flag_sw_clr[2]);
      if (ctr2_external_flag_tog && !flag_sw_set[3] && !flag_sw_clr[3]) begin
        ctr2_external_flag <= ~ctr2_external_flag;
      end else begin
        ctr2_external_flag <= flag_nxt(ctr2_external_flag, ctr2_external_flag_set, flag_sw_set[3],
                                       flag_sw_clr[3]);
      end
    end
  end

  // Interrupt requests follow the flag registers by one cycle; ctr2_irq ignores the external flag in up/down mode
  always_ff @(posedge clk) begin
    if (reset) begin
      ctr0_irq <= 1'b0;
      ctr1_irq <= 1'b0;
      ctr2_irq <= 1'b0;
    end else begin
      ctr0_irq <= ctr0_overflow_flag;
      ctr1_irq <= ctr1_overflow_flag;
      ctr2_irq <= ctr2_overflow_flag |
                  (ctr2_external_flag & (c2mode != TTC_C2_UP_DOWN));
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_baud_tick <= 1'b0;
      rx_baud_tick <= 1'b0;
      clock_out_pin <= 1'b0;
      clock_out_oe_n <= 1'b1;
    end else begin
      tx_baud_tick <= tx_baud_from_ctr2 ? c2_ovf : c1_ovf;
      rx_baud_tick <= rx_baud_from_ctr2 ? c2_ovf : c1_ovf;
      clock_out_oe_n <= ~clkout_mode;
      if (clkout_mode && c2_ovf) clock_out_pin <= ~clock_out_pin;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_vector_clears: assert property (@(posedge clk) disable iff (reset)
    ctr0_vector_ack && !c0_ovf && !flag_sw_set[0] |=> !ctr0_overflow_flag)
    else $error("ctr0 flag not cleared on vector");
  a_set_wins: assert property (@(posedge clk) disable iff (reset)
    c0_ovf && ctr0_vector_ack |=> ctr0_overflow_flag)
    else $error("ctr0 overflow lost against clear");
  a_mode1_hold: assert property (@(posedge clk) disable iff (reset)
    ctr1_mode == TTC_MSPLIT && !ctr1_wr |=> $stable(ctr1_count))
    else $error("ctr1 moved in mode 3");
  a_stop_hold: assert property (@(posedge clk) disable iff (reset)
    !ctr0_run && !ctr0_wr && ctr0_mode != TTC_MSPLIT |=> $stable(ctr0_count))
    else $error("ctr0 counted while stopped");
  a_reload_mode2: assert property (@(posedge clk) disable iff (reset)
    ctr0_mode == TTC_M8R && c0_ovf && !ctr0_wr |=> ctr0_count[7:0] == ctr0_count[15:8])
    else $error("mode 2 reload wrong");
  a_baud_no_tf2: assert property (@(posedge clk) disable iff (reset)
    baud_sel && !flag_sw_set[2] && !ctr2_overflow_flag |=> !ctr2_overflow_flag)
    else $error("tf set in baud mode");
  a_down_load: assert property (@(posedge clk) disable iff (reset)
    c2mode == TTC_C2_UP_DOWN && c2_ovf && !up2 && !ctr2_wr |=> ctr2_count == 16'hffff)
    else $error("down overflow load wrong");
  a_clkout_tog: assert property (@(posedge clk) disable iff (reset)
    clkout_mode && c2_ovf |=> clock_out_pin != $past(clock_out_pin))
    else $error("clock out did not toggle");
  a_capture: assert property (@(posedge clk) disable iff (reset)
    c2_capture |=> {reload_capture_high, reload_capture_low} == $past(ctr2_count))
    else $error("capture value wrong");
  a_tick_spacing: assert property (@(posedge clk) disable iff (reset)
    tick && mode_12t |=> !tick [*5])
    else $error("machine cycle too short");
endmodule // ttc_unit
`default_nettype wire

// File: rtl/ttc_pkg.sv
// Purpose: Constants and types shared by the triple timer/counter unit
// Assumes: 10 MHz clk; one machine cycle is 12 or 6 clk cycles
// Notes: No register bus; control bits arrive as plain ports
package ttc_pkg;
  localparam int unsigned TTC_CLK_HZ = 10000000;
  localparam logic [3:0] TTC_MC_12T = 4'hc;
  localparam logic [3:0] TTC_MC_6T = 4'h6;
  localparam logic [15:0] TTC_RESET_COUNT = 16'h0000;
  localparam logic [15:0] TTC_DOWN_LOAD = 16'hffff;
  localparam logic [4:0] TTC_PRESCALE_MAX = 5'h1f;
  localparam int TTC_PRESCALE_MSB = 4;

  typedef enum logic [1:0] {
    TTC_M13 = 2'h0,
    TTC_M16 = 2'h1,
    TTC_M8R = 2'h2,
    TTC_MSPLIT = 2'h3
  } ttc_mode01_t;

  typedef enum logic [4:0] {
    TTC_C2_OFF = 5'h01,
    TTC_C2_BAUD = 5'h02,
    TTC_C2_CAPTURE = 5'h04,
    TTC_C2_UP_ONLY = 5'h08,
    TTC_C2_UP_DOWN = 5'h10
  } ttc_c2mode_t;
endpackage

// File: rtl/ttc_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module ttc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // ttc_sync
`default_nettype wire

// File: rtl/ttc_mcycle.sv
// Purpose: Machine-cycle enable from the oscillator clock
// Assumes: mode_12t selects 12 or 6 clocks per cycle
// Notes: tick is one clk wide
`timescale 1ns/1ps
`default_nettype none
module ttc_mcycle (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic mode_12t,
  output logic tick
);
  import ttc_pkg::*;
  logic [3:0] cnt_r;
  logic [3:0] last;

  assign last = mode_12t ? (TTC_MC_12T - 4'h1) : (TTC_MC_6T - 4'h1);

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= 4'h0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r >= last);
      cnt_r <= (cnt_r >= last) ? 4'h0 : cnt_r + 4'h1;
    end
  end
endmodule // ttc_mcycle
`default_nettype wire

// File: verif/ttc_cpu_model.sv
// Purpose: CPU side model: vectors timer 0/1 requests, counts baud ticks
// Assumes: Drives the vector acks 1 ns after the rising edge; tick counts update at the edge
// Notes: ACK_DELAY cycles pass between a request and its vector
`timescale 1ns/1ps
`default_nettype none
module ttc_cpu_model #(
  parameter int ACK_DELAY = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Requests and ticks
  input wire logic ack_en,
  input wire logic ctr0_irq,
  input wire logic ctr1_irq,
  input wire logic tx_baud_tick,
  input wire logic rx_baud_tick,
  input wire logic cnt_clr,
  // Vectoring and tick counts
  output logic ctr0_vector_ack,
  output logic ctr1_vector_ack,
  output var int tx_cnt,
  output var int rx_cnt
);
  int w0 = 0;
  int w1 = 0;

  initial begin
    {ctr0_vector_ack, ctr1_vector_ack} = 2'h0;
    {tx_cnt, rx_cnt} = '0;
  end

  always @(posedge clk) begin
    // Ticks are one clock wide, so count each sampled high
    tx_cnt = cnt_clr ? 0 : tx_cnt + (tx_baud_tick === 1'b1 ? 1 : 0);
    rx_cnt = cnt_clr ? 0 : rx_cnt + (rx_baud_tick === 1'b1 ? 1 : 0);
    #1;
    w0 = (ctr0_irq === 1'b1 && ack_en && !reset) ? w0 + 1 : 0;
    w1 = (ctr1_irq === 1'b1 && ack_en && !reset) ? w1 + 1 : 0;
    ctr0_vector_ack = (w0 == ACK_DELAY);
    ctr1_vector_ack = (w1 == ACK_DELAY);
    if (w0 == ACK_DELAY) w0 = 0;
    if (w1 == ACK_DELAY) w1 = 0;
  end
endmodule // ttc_cpu_model
`default_nettype wire

// File: verif/tb.sv
// Purpose: Self-checking bench for the triple timer/counter unit
// Assumes: 6T machine cycle until the clock-out test
// Notes: Waits are bounded; the CPU model acks counter 0/1 vectors
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, reset, mode_12t, ctr0_count_pin, ctr1_count_pin, ctr2_count_pin;
  logic ext_int0_pin, ext_int1_pin, ctr2_trigger_pin, clock_out_pin, clock_out_oe_n;
  logic [1:0] ctr0_mode, ctr1_mode;
  logic ctr0_counter_select, ctr0_gate, ctr0_run, ctr1_counter_select, ctr1_gate, ctr1_run;
  logic ctr2_run, ctr2_counter_select, capture_not_reload, ctr2_trigger_allow;
  logic down_count_allow, tx_baud_from_ctr2, rx_baud_from_ctr2, clock_out_enable;
  logic [7:0] reload_capture_low_in, reload_capture_high_in;
  logic [7:0] reload_capture_low, reload_capture_high;
  logic [15:0] ctr0_wdata, ctr1_wdata, ctr2_wdata, ctr0_count, ctr1_count, ctr2_count;
  logic ctr0_wr, ctr1_wr, ctr2_wr, rcap_wr, ctr0_vector_ack, ctr1_vector_ack;
  logic [3:0] flag_sw_set, flag_sw_clr;
  logic ctr0_overflow_flag, ctr1_overflow_flag, ctr2_overflow_flag, ctr2_external_flag;
  logic ctr0_irq, ctr1_irq, ctr2_irq, tx_baud_tick, rx_baud_tick, ack_en, cnt_clr;
  int tx_cnt, rx_cnt, error_cnt, checks, n;
  wire logic [3:0] flags = {ctr2_external_flag, ctr2_overflow_flag, ctr1_overflow_flag,
    ctr0_overflow_flag};

  ttc_unit i_ttc_unit (.*);
  ttc_cpu_model i_ttc_cpu_model (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("unexpected at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Index 0..2 loads a counter, 3 the reload/capture bytes
  task automatic load(input int c, input logic [15:0] d);
    {ctr0_wdata, ctr1_wdata, ctr2_wdata} = {3{d}};
    {reload_capture_high_in, reload_capture_low_in} = d;
    {rcap_wr, ctr2_wr, ctr1_wr, ctr0_wr} = 4'h1 << c;
    cyc(1);
    {rcap_wr, ctr2_wr, ctr1_wr, ctr0_wr} = 4'h0;
    cyc(1);
  endtask

  task automatic swf(input logic [3:0] s, input logic [3:0] c);
    flag_sw_set = s;
    flag_sw_clr = c;
    cyc(1);
    {flag_sw_set, flag_sw_clr} = 8'h00;
  endtask

  task automatic wait_flag(input int f);
    int w;
    w = 0;
    while (flags[f] !== 1'b1 && w < 2000) begin
      cyc(1);
      w++;
    end
    chk(flags[f], 1);
  endtask

  task automatic falls(input int k);
    repeat (k) begin
      ctr0_count_pin = 1'b1;
      cyc(20);
      ctr0_count_pin = 1'b0;
      cyc(20);
    end
  endtask

  task automatic trig_fall;
    ctr2_trigger_pin = 1'b0;
    cyc(30);
    ctr2_trigger_pin = 1'b1;
    cyc(30);
  endtask

  task automatic half_period(output int p);
    logic b;
    repeat (2) begin
      b = clock_out_pin;
      p = 0;
      while (clock_out_pin === b && p < 200) begin
        cyc(1);
        p++;
      end
    end
  endtask

  task automatic done(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {reset, mode_12t, ctr0_count_pin, ctr1_count_pin, ctr2_count_pin, ext_int0_pin} = 6'h20;
    {ext_int1_pin, ctr0_mode, ctr1_mode, ctr0_counter_select, ctr0_gate, ctr0_run} = '0;
    {ctr1_counter_select, ctr1_gate, ctr1_run, ctr2_run, ctr2_counter_select} = '0;
    {capture_not_reload, ctr2_trigger_allow, down_count_allow, tx_baud_from_ctr2} = '0;
    {rx_baud_from_ctr2, clock_out_enable, reload_capture_low_in, reload_capture_high_in} = '0;
    {ctr0_wdata, ctr1_wdata, ctr2_wdata, ctr0_wr, ctr1_wr, ctr2_wr, rcap_wr} = '0;
    {flag_sw_set, flag_sw_clr, cnt_clr, error_cnt, checks} = '0;
    {ctr2_trigger_pin, ack_en} = 2'h3;
    cyc(16);
    reset = 1'b0;
    chk(ctr0_count | ctr1_count | ctr2_count, 0);
    chk({flags, ctr2_irq, clock_out_oe_n, clock_out_pin}, 32'h2);
    ctr0_mode = 2'h1;
    load(0, 16'hffe0);
    ctr0_run = 1'b1;
    wait_flag(0);
    chk(ctr0_count, 16'h0000);
    ctr0_run = 1'b0;
    cyc(1);
    chk(ctr0_irq, 1);
    cyc(8);
    chk({ctr0_overflow_flag, ctr0_irq}, 0);
    ctr0_mode = 2'h0;
    load(0, 16'hffff);
    ctr0_run = 1'b1;
    wait_flag(0);
    chk(ctr0_count, 16'h00e0);
    done("wrap");
    {ctr0_mode, ctr0_counter_select, ctr0_gate} = 4'h7;
    load(0, 16'h0000);
    falls(3);
    chk(ctr0_count, 0);
    ext_int0_pin = 1'b1;
    falls(3);
    chk(ctr0_count, 16'h0003);
    {ctr0_mode, ctr0_counter_select, ctr0_gate} = 4'h8;
    load(0, 16'h80fe);
    wait_flag(0);
    chk(ctr0_count, 16'h8080);
    {ctr0_run, ctr0_counter_select, ctr0_gate} = 3'h0;
    swf(4'h0, 4'h1);
    load(1, 16'h1234);
    load(0, 16'hff55);
    {ctr0_mode, ctr1_mode, ctr1_run} = 5'h1f;
    wait_flag(1);
    chk(ctr0_count, 16'h0055);
    chk(ctr1_count, 16'h1234);
    chk(ctr0_overflow_flag, 0);
    cyc(1);
    chk(ctr1_irq, 1);
    ctr1_run = 1'b0;
    done("gate and split");
    load(3, 16'h1234);
    load(2, 16'hfffe);
    ctr2_run = 1'b1;
    wait_flag(2);
    chk(ctr2_count, 16'h1234);
    cyc(6);
    chk({ctr2_overflow_flag, ctr2_irq}, 2'h3);
    {ctr2_counter_select, ctr2_trigger_allow} = 2'h3;
    swf(4'h0, 4'h4);
    load(2, 16'h5000);
    trig_fall;
    chk({ctr2_count, ctr2_external_flag}, {16'h1234, 1'b1});
    capture_not_reload = 1'b1;
    swf(4'h0, 4'h8);
    load(2, 16'h4321);
    trig_fall;
    chk({reload_capture_high, reload_capture_low, ctr2_external_flag}, 32'h8643);
    chk(ctr2_irq, 1);
    swf(4'h0, 4'hc);
    cyc(2);
    chk(ctr2_irq, 0);
    swf(4'h8, 4'h0);
    cyc(2);
    chk(ctr2_irq, 1);
    swf(4'h0, 4'h8);
    done("reload and capture");
    {capture_not_reload, ctr2_trigger_allow, ctr2_counter_select, down_count_allow} = 4'h1;
    ctr2_trigger_pin = 1'b0;
    load(3, 16'h1000);
    load(2, 16'h1003);
    wait_flag(2);
    chk({ctr2_count, ctr2_external_flag}, {16'hffff, 1'b1});
    swf(4'h0, 4'h4);
    cyc(2);
    chk(ctr2_irq, 0);
    ctr2_trigger_pin = 1'b1;
    load(2, 16'hfffe);
    wait_flag(2);
    chk({ctr2_count, ctr2_external_flag}, {16'h1000, 1'b0});
    down_count_allow = 1'b0;
    done("up down");
    {tx_baud_from_ctr2, capture_not_reload, ctr1_mode, ctr1_run} = 5'h1d;
    load(3, 16'hfffe);
    load(2, 16'hfffe);
    load(1, 16'hffff);
    swf(4'h0, 4'h4);
    for (int k = 0; k < 2; k++) begin
      cnt_clr = 1'b1;
      cyc(1);
      cnt_clr = 1'b0;
      cyc(120);
      chk_rng(k ? rx_cnt : tx_cnt, 9, 11);
      chk_rng(k ? tx_cnt : rx_cnt, 19, 21);
      {tx_baud_from_ctr2, rx_baud_from_ctr2} = 2'h1;
    end
    chk({ctr2_overflow_flag, ctr2_count[15:1]}, 16'h7fff);
    done("baud");
    {tx_baud_from_ctr2, rx_baud_from_ctr2, capture_not_reload, ctr1_run} = 4'h0;
    clock_out_enable = 1'b1;
    load(3, 16'hfffc);
    load(2, 16'hfffc);
    swf(4'h0, 4'hf);
    for (int k = 0; k < 2; k++) begin
      half_period(n);
      chk_rng(n, 24 << k, 24 << k);
      mode_12t = 1'b1;
      half_period(n);
    end
    chk({clock_out_oe_n, ctr2_irq}, 0);
    done("clock out");
    stop_test;
  end
endmodule // tb
`default_nettype wire
